// ---- hdl/dts_top.sv ----
// debug test-bus selector: command parser, wishbone slave and pad routing
`timescale 1ns/1ns
module dts_top
  import dts_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // nonvolatile setting
  input  wire logic        debug_bus_enable_setting_i,
  // signal groups
  input  wire logic        rf_clock_i,
  input  wire logic [7:0]  clock_grp_i,
  input  wire logic [7:0]  tx_enc_grp_i,
  input  wire logic [7:0]  timer_grp_i,
  input  wire logic [7:0]  card_grp_i,
  input  wire logic [7:0]  trx_grp_i,
  input  wire logic [7:0]  rx_data_grp_i,
  input  wire logic [7:0]  rx_err_grp_i,
  // digital pads: irq, aux one, aux two, general output
  output logic [3:0]       pad_o,
  // analog routing to the aux pads
  output logic             analog_active_o,
  output logic [7:0]       aux_pad_one_analog_o,
  output logic [7:0]       aux_pad_two_analog_o
);

  // parser and routing state
  dts_state_t  state_r,   state_nxt;
  logic [7:0]  cmd_grp_r, cmd_grp_nxt;
  logic [1:0]  route_cnt_r, route_cnt_nxt;
  logic [7:0]  pad_grp_r [DTS_NUM_PADS];
  logic [7:0]  pad_grp_nxt [DTS_NUM_PADS];
  logic [3:0]  pad_idx_r [DTS_NUM_PADS];
  logic [3:0]  pad_idx_nxt [DTS_NUM_PADS];
  logic [3:0]  pad_on_r,  pad_on_nxt;
  logic        ana_on_r,  ana_on_nxt;
  logic [7:0]  ana_one_r, ana_one_nxt;
  logic [7:0]  ana_two_r, ana_two_nxt;
  // bus state
  logic        ack_r,     ack_nxt;
  logic [31:0] rdat_r,    rdat_nxt;
  // pad outputs
  logic [3:0]  pad_r,     pad_nxt;
  logic [3:0]  mux_bit;
  logic        ana_act_nxt;

  logic        bus_req;
  logic        byte_wr;
  logic        end_wr;
  logic [7:0]  wbyte;
  logic [3:0]  rt_pad;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign byte_wr = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == DTS_CMD_BYTE_OFS);
  assign end_wr  = bus_req & wb_we_i & (wb_adr_i == DTS_CMD_END_OFS);
  assign wbyte   = wb_dat_i[7:0];
  assign rt_pad  = wbyte[7:4];

  // command parser: each byte written to the command register advances it, except an unknown code while idle
  always_comb begin
    state_nxt     = state_r;
    cmd_grp_nxt   = cmd_grp_r;
    route_cnt_nxt = route_cnt_r;
    pad_grp_nxt   = pad_grp_r;
    pad_idx_nxt   = pad_idx_r;
    pad_on_nxt    = pad_on_r;
    ana_on_nxt    = ana_on_r;
    ana_one_nxt   = ana_one_r;
    ana_two_nxt   = ana_two_r;
    if (end_wr) begin
      state_nxt = DTS_ST_IDLE; // the end write closes any command at once; a digital command also closes by itself after its fourth routing byte
    end else if (byte_wr) begin
      case (state_r)
        DTS_ST_IDLE: begin
          if (wbyte == DTS_DIGITAL_ROUTE_CMD) begin
            state_nxt = DTS_ST_GROUP;
          end else if (wbyte == DTS_ANALOG_ROUTE_CMD) begin
            state_nxt = DTS_ST_ANA2;
          end
        end
        DTS_ST_GROUP: begin
          cmd_grp_nxt   = wbyte;
          route_cnt_nxt = 2'h0;
          state_nxt     = DTS_ST_ROUTE;
        end
        DTS_ST_ROUTE: begin
          // pads 4..15 are reserved and ignored
          if (rt_pad <= DTS_PAD_GPO) begin
            pad_grp_nxt[rt_pad[1:0]] = cmd_grp_r;
            pad_idx_nxt[rt_pad[1:0]] = wbyte[3:0];
            pad_on_nxt[rt_pad[1:0]]  = 1'b1;
          end
          route_cnt_nxt = route_cnt_r + 2'h1;
          if (route_cnt_r == DTS_LAST_ROUTE) begin
            state_nxt = DTS_ST_IDLE;
          end
        end
        DTS_ST_ANA2: begin
          ana_two_nxt = wbyte;
          state_nxt   = DTS_ST_ANA1;
        end
        DTS_ST_ANA1: begin
          ana_one_nxt = wbyte;
          ana_on_nxt  = 1'b1;
          state_nxt   = DTS_ST_IDLE;
        end
        default: state_nxt = DTS_ST_IDLE;
      endcase
    end
  end

  // parser registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= DTS_ST_IDLE;
      cmd_grp_r   <= DTS_GROUP_RST;
      route_cnt_r <= 2'h0;
      pad_on_r    <= 4'h0;
      ana_on_r    <= 1'b0;
      ana_one_r   <= DTS_ANALOG_RST;
      ana_two_r   <= DTS_ANALOG_RST;
      for (int i = 0; i < DTS_NUM_PADS; i++) begin
        pad_grp_r[i] <= DTS_GROUP_RST;
        pad_idx_r[i] <= DTS_INDEX_RST;
      end
    end else if (ce_i) begin
      state_r     <= state_nxt;
      cmd_grp_r   <= cmd_grp_nxt;
      route_cnt_r <= route_cnt_nxt;
      pad_on_r    <= pad_on_nxt;
      ana_on_r    <= ana_on_nxt;
      ana_one_r   <= ana_one_nxt;
      ana_two_r   <= ana_two_nxt;
      pad_grp_r   <= pad_grp_nxt;
      pad_idx_r   <= pad_idx_nxt;
    end
  end

  // one selector per pad
  genvar g;
  generate
    for (g = 0; g < DTS_NUM_PADS; g++) begin : gen_pad
      dts_pad_mux u_mux (
        .group_i       (pad_grp_r[g]),
        .index_i       (pad_idx_r[g]),
        .rf_clock_i    (rf_clock_i),
        .clock_grp_i   (clock_grp_i),
        .tx_enc_grp_i  (tx_enc_grp_i),
        .timer_grp_i   (timer_grp_i),
        .card_grp_i    (card_grp_i),
        .trx_grp_i     (trx_grp_i),
        .rx_data_grp_i (rx_data_grp_i),
        .rx_err_grp_i  (rx_err_grp_i),
        .sel_o         (mux_bit[g])
      );
    end
  endgenerate

  // pads and the analog active flag stay off unless the enable setting is on
  always_comb begin
    pad_nxt     = pad_on_r & mux_bit & {DTS_NUM_PADS{debug_bus_enable_setting_i}};
    ana_act_nxt = ana_on_r & debug_bus_enable_setting_i;
  end

  // wishbone answer: one-cycle ack, unmapped reads return zero
  always_comb begin
    ack_nxt  = bus_req;
    rdat_nxt = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        DTS_STATUS_OFS: rdat_nxt = {24'h00_0000, pad_on_r, ana_on_r, state_r};
        DTS_ROUTE_OFS:  rdat_nxt = {16'h0000, pad_idx_r[3], pad_idx_r[2], pad_idx_r[1], pad_idx_r[0]};
        DTS_ANALOG_OFS: rdat_nxt = {15'h0000, debug_bus_enable_setting_i, ana_one_r, ana_two_r};
        default:        rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bus and pad registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
      pad_r  <= 4'h0;
    end else if (ce_i) begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
      pad_r  <= pad_nxt;
    end
  end

  // analog routing outputs, registered; only the active flag waits for the enable setting
  logic       ana_act_r;
  logic [7:0] ana_one_o_r;
  logic [7:0] ana_two_o_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_act_r   <= 1'b0;
      ana_one_o_r <= DTS_ANALOG_RST;
      ana_two_o_r <= DTS_ANALOG_RST;
    end else if (ce_i) begin
      ana_act_r   <= ana_act_nxt;
      ana_one_o_r <= ana_one_r;
      ana_two_o_r <= ana_two_r;
    end
  end

  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = rdat_r;
  assign pad_o                = pad_r;
  assign analog_active_o      = ana_act_r;
  assign aux_pad_one_analog_o = ana_one_o_r;
  assign aux_pad_two_analog_o = ana_two_o_r;

endmodule

// ---- hdl/dts_pkg.sv ----
// constants and types shared by the debug test-bus selector
package dts_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] DTS_CMD_BYTE_OFS  = 8'h00;
  localparam logic [7:0] DTS_CMD_END_OFS   = 8'h04;
  localparam logic [7:0] DTS_STATUS_OFS    = 8'h08;
  localparam logic [7:0] DTS_ROUTE_OFS     = 8'h0C;
  localparam logic [7:0] DTS_ANALOG_OFS    = 8'h10;

  // command codes
  localparam logic [7:0] DTS_DIGITAL_ROUTE_CMD = 8'h18;
  localparam logic [7:0] DTS_ANALOG_ROUTE_CMD  = 8'h19;

  // nonvolatile address of the enable setting (held outside this block)
  localparam logic [7:0] DTS_ENABLE_NV_ADDR = 8'h17;

  // group selector codes
  localparam logic [7:0] DTS_GRP_CLOCK    = 8'h01;
  localparam logic [7:0] DTS_GRP_TX_ENC   = 8'h1B;
  localparam logic [7:0] DTS_GRP_TIMER    = 8'h1D;
  localparam logic [7:0] DTS_GRP_CARD     = 8'h30;
  localparam logic [7:0] DTS_GRP_TRX      = 8'h58;
  localparam logic [7:0] DTS_GRP_RX_DATA  = 8'h70;
  localparam logic [7:0] DTS_GRP_RX_ERR   = 8'h73;

  // valid index masks per group for indices 7..0 (zero bits are reserved)
  localparam logic [7:0] DTS_MASK_CLOCK   = 8'hFF;
  localparam logic [7:0] DTS_MASK_TX_ENC  = 8'h03;
  localparam logic [7:0] DTS_MASK_TIMER   = 8'hFC;
  localparam logic [7:0] DTS_MASK_CARD    = 8'hFF;
  localparam logic [7:0] DTS_MASK_TRX     = 8'hFF;
  localparam logic [7:0] DTS_MASK_RX_DATA = 8'hFF;
  localparam logic [7:0] DTS_MASK_RX_ERR  = 8'hC7;

  // index that selects the shared rf clock in every group
  localparam logic [3:0] DTS_IDX_RF_CLOCK = 4'h8;

  // pad numbers and count
  localparam int         DTS_NUM_PADS     = 4;
  localparam logic [3:0] DTS_PAD_IRQ      = 4'h0;
  localparam logic [3:0] DTS_PAD_AUX_ONE  = 4'h1;
  localparam logic [3:0] DTS_PAD_AUX_TWO  = 4'h2;
  localparam logic [3:0] DTS_PAD_GPO      = 4'h3;

  // most routing bytes in one digital command, minus one
  localparam logic [1:0] DTS_LAST_ROUTE   = 2'h3;

  // reset values
  localparam logic [7:0] DTS_GROUP_RST    = 8'h00;
  localparam logic [3:0] DTS_INDEX_RST    = 4'h0;
  localparam logic [7:0] DTS_ANALOG_RST   = 8'h00;

  // command parser states
  typedef enum logic [2:0] {
    DTS_ST_IDLE  = 3'b000,
    DTS_ST_GROUP = 3'b001,
    DTS_ST_ROUTE = 3'b010,
    DTS_ST_ANA2  = 3'b011,
    DTS_ST_ANA1  = 3'b100
  } dts_state_t;

endpackage

// ---- hdl/dts_pad_mux.sv ----
// one pad's signal selector: group code plus index to a single bit
`timescale 1ns/1ns
module dts_pad_mux
  import dts_pkg::*;
(
  // selection
  input  wire logic [7:0] group_i,
  input  wire logic [3:0] index_i,
  // signal groups
  input  wire logic       rf_clock_i,
  input  wire logic [7:0] clock_grp_i,
  input  wire logic [7:0] tx_enc_grp_i,
  input  wire logic [7:0] timer_grp_i,
  input  wire logic [7:0] card_grp_i,
  input  wire logic [7:0] trx_grp_i,
  input  wire logic [7:0] rx_data_grp_i,
  input  wire logic [7:0] rx_err_grp_i,
  // selected bit
  output logic            sel_o
);

  logic [7:0] vec;
  logic       known;

  // pick the group vector with reserved indices forced low
  always_comb begin
    vec   = 8'h00;
    known = 1'b1;
    case (group_i)
      DTS_GRP_CLOCK:   vec = clock_grp_i   & DTS_MASK_CLOCK;
      DTS_GRP_TX_ENC:  vec = tx_enc_grp_i  & DTS_MASK_TX_ENC;
      DTS_GRP_TIMER:   vec = timer_grp_i   & DTS_MASK_TIMER;
      DTS_GRP_CARD:    vec = card_grp_i    & DTS_MASK_CARD;
      DTS_GRP_TRX:     vec = trx_grp_i     & DTS_MASK_TRX;
      DTS_GRP_RX_DATA: vec = rx_data_grp_i & DTS_MASK_RX_DATA;
      DTS_GRP_RX_ERR:  vec = rx_err_grp_i  & DTS_MASK_RX_ERR;
      default:         known = 1'b0;
    endcase
  end

  // index 8 is the rf clock, 9..15 reserved and low
  always_comb begin
    if (!known) begin
      sel_o = 1'b0;
    end else if (index_i == DTS_IDX_RF_CLOCK) begin
      sel_o = rf_clock_i;
    end else if (index_i[3]) begin
      sel_o = 1'b0;
    end else begin
      sel_o = vec[index_i[2:0]];
    end
  end

endmodule

// ---- verif/dts_top_assertions.sv ----
// concurrent checks on the debug test-bus selector ports
`timescale 1ns/1ns
module dts_top_assertions
  import dts_pkg::*;
(
  // clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // enable setting and outputs
  input wire logic        debug_bus_enable_setting_i,
  input wire logic [3:0]  pad_o,
  input wire logic        analog_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request the slave must take at this edge
  sequence bus_req;
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
  endsequence
  ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack without strobe");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  unmapped_rd_a: assert property (bus_req ##0 (!wb_we_i && wb_adr_i > 8'h13) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  pad_gate_a: assert property (ce_i && !debug_bus_enable_setting_i |=> pad_o == 4'h0) else $error("pad live");
  analog_gate_a: assert property (ce_i && !debug_bus_enable_setting_i |=> !analog_active_o)
    else $error("analog live while disabled");
  pad_rise_a: assert property ($rose(pad_o[0]) |-> $past(debug_bus_enable_setting_i))
    else $error("pad rose while disabled");
endmodule

bind dts_top dts_top_assertions dts_top_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .debug_bus_enable_setting_i(debug_bus_enable_setting_i), .pad_o(pad_o),
  .analog_active_o(analog_active_o)
);

// ---- verif/dts_host_model.sv ----
// host model: wishbone master cycles and debug route command framing
`timescale 1ns/1ns
module dts_host_model
  import dts_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // wishbone master side
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  // byte lanes used by the next cycle
  logic [3:0] lanes = 4'hF;
  // idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0;
  end
  // one classic cycle, held until ack, then one idle cycle before the next
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= lanes;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~d; // released data no longer shows the last value
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h0, d}, q);
  endtask
  // digital route: code, group, one route byte, then close the command
  task automatic route(input logic [7:0] g, input logic [7:0] b);
    wr(DTS_CMD_BYTE_OFS, 8'h18);
    wr(DTS_CMD_BYTE_OFS, g);
    wr(DTS_CMD_BYTE_OFS, b);
    wr(DTS_CMD_END_OFS, 8'h00);
  endtask
  // analog route: first byte for aux two, second for aux one
  task automatic analog(input logic [7:0] a, input logic [7:0] b);
    wr(DTS_CMD_BYTE_OFS, 8'h19);
    wr(DTS_CMD_BYTE_OFS, a);
    wr(DTS_CMD_BYTE_OFS, b);
  endtask
endmodule

// ---- verif/dts_top_tb_top.sv ----
// self-checking bench for the debug test-bus selector
`timescale 1ns/1ns
module dts_top_tb_top;
  import dts_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             en    = 1'b1;
  logic             ce    = 1'b1;
  logic             rf    = 1'b0;
  logic [7:0]       grp [7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  logic [7:0]       codes [7] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  logic [7:0]       masks [7] = '{8'hFF, 8'h03, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
  logic [31:0]      rd;
  wire logic        cyc, stb, we, ack, act;
  wire logic [7:0]  adr, a1, a2;
  wire logic [3:0]  sel, pad;
  wire logic [31:0] dw, dr;
  int               failures = 0;
  int               samples_checked = 0;
  always #50 clk_i = ~clk_i;
  dts_top dts_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .debug_bus_enable_setting_i(en), .rf_clock_i(rf), .clock_grp_i(grp[0]), .tx_enc_grp_i(grp[1]),
    .timer_grp_i(grp[2]), .card_grp_i(grp[3]), .trx_grp_i(grp[4]), .rx_data_grp_i(grp[5]),
    .rx_err_grp_i(grp[6]), .pad_o(pad), .analog_active_o(act), .aux_pad_one_analog_o(a1),
    .aux_pad_two_analog_o(a2));
  dts_host_model dts_host_model_inst (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_ack_i(ack), .wb_dat_i(dr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t pad bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // every group and indices 0 to 9 on a rotating pad, selected bit alone high then alone low
  task automatic t_mux;
    logic [7:0] s;
    logic       e;
    for (int g = 0; g < 7; g++) begin
      for (int i = 0; i < 10; i++) begin
        s = (i < 8) ? 8'(1 << i) : 8'h00;
        e = (i < 8) ? masks[g][i] : (i == 8);
        dts_host_model_inst.route(codes[g], {4'(i % 4), 4'(i)});
        for (int k = 0; k < 2; k++) begin
          foreach (grp[j]) grp[j] <= ((j == g) != (k == 1)) ? s : ~s;
          rf <= (k == 1) ? (i != 8) : (i == 8);
          repeat (2) @(posedge clk_i);
          chk_bit(pad[i % 4], e && (k == 0));
        end
      end
    end
  endtask
  // four route bytes in one command, then the enable setting gates the pads
  task automatic t_enable;
    grp[0] <= 8'h10;
    dts_host_model_inst.wr(DTS_CMD_BYTE_OFS, 8'h18);
    dts_host_model_inst.wr(DTS_CMD_BYTE_OFS, 8'h01);
    for (int p = 0; p < 4; p++) dts_host_model_inst.wr(DTS_CMD_BYTE_OFS, {4'(p), 4'h4});
    dts_host_model_inst.xfer(1'b0, DTS_STATUS_OFS, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'hF0);
    chk({28'h0, pad}, 32'hF);
    // clock enable low freezes the pads although the routed input changes
    ce     <= 1'b0;
    grp[0] <= 8'h00;
    repeat (2) @(posedge clk_i);
    chk({28'h0, pad}, 32'hF);
    ce     <= 1'b1;
    grp[0] <= 8'h10;
    en <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({28'h0, pad}, 32'h0);
    en <= 1'b1;
  endtask
  // unknown group, reserved pad, ignored byte lane and parser state in the status view
  task automatic t_misc;
    rf <= 1'b1;
    dts_host_model_inst.route(8'h55, 8'h08);
    dts_host_model_inst.route(8'h01, 8'h48);
    chk({28'h0, pad}, 32'hE);
    dts_host_model_inst.xfer(1'b0, DTS_ROUTE_OFS, 32'h0, rd);
    chk(rd, 32'h4448);
    dts_host_model_inst.lanes = 4'h0;
    dts_host_model_inst.wr(DTS_CMD_BYTE_OFS, 8'h18);
    dts_host_model_inst.lanes = 4'hF;
    dts_host_model_inst.xfer(1'b0, DTS_STATUS_OFS, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'hF0);
    dts_host_model_inst.wr(DTS_CMD_BYTE_OFS, 8'h18);
    dts_host_model_inst.xfer(1'b0, DTS_STATUS_OFS, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'hF1);
    dts_host_model_inst.wr(DTS_CMD_END_OFS, 8'h00);
  endtask
  // analog command order, its register view, an unmapped read and gating
  task automatic t_analog;
    dts_host_model_inst.analog(8'h05, 8'h0A);
    repeat (2) @(posedge clk_i);
    chk({15'h0, act, a1, a2}, 32'h10A05);
    dts_host_model_inst.xfer(1'b0, DTS_ANALOG_OFS, 32'h0, rd);
    chk(rd, 32'h10A05);
    dts_host_model_inst.xfer(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    en <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, act}, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, pad}, 32'h0);
    t_mux();
    t_enable();
    t_misc();
    t_analog();
    end_sim();
  end
endmodule
